// File: led_cfg_pkg.sv
// Constants for the LED driver configuration register bank.
// Assumes a single 25 MHz clock domain; all pins are synchronous to it.
// Function
// - Regulator runs only while its enable pin is high.
// - Bit 15 steers word to config 0 or 1.
// - Config 0 bit 0 enables the device.
// - Config 0 bit 2 reports regulation DAC overflow.
// - Bits 4 and 5 auto-disconnect open, shorted channels.
// - Config 0 bit 11 selects current range.
// - Bit 13 enables vout regulation; bit 12 reports optimized.
// - Bits 8 and 9 select short-detection threshold.
// - Bit 10 grayscale mode; bit 14 slaves present.
// - Config 1 bits 9, 10 select brightness format, resolution.
// - Config 1 bit 11 sets dimming phase order.
// - Bit 12 low applies brightness at latch fall.
// - Config 1 bit 13 selects sync pin mode.
// - Config 1 bit 14 enables continuous status reading.
// - Device enable locks range, slave, sync mode bits.
// - Channel faults stick until device enable toggles or the regulator pin goes low.
package led_cfg_pkg;
   localparam int WORD_W = 16;              // Width of a shifted word
   typedef logic [WORD_W-1:0] word_t;       // One configuration word
   // Shared bit position: destination select
   localparam int DESTINATION_SELECT_BIT = 15;
   // Configuration word 0 field positions
   localparam int C0_DEV_EN = 0;
   localparam int C0_SCAN_VALID = 1;
   localparam int C0_DAC_OVF = 2;
   localparam int C0_OVERTEMP = 3;
   localparam int C0_OPEN_AD = 4;
   localparam int C0_SHORT_AD = 5;
   localparam int C0_PROT_EVT = 6;
   localparam int C0_WIN_SEL = 7;
   localparam int C0_THR0 = 8;
   localparam int C0_THR1 = 9;
   localparam int C0_GRAY_EN = 10;
   localparam int C0_CUR_RANGE = 11;
   localparam int C0_VOUT_OPT = 12;
   localparam int C0_VOUT_REG_EN = 13;
   localparam int C0_SLAVE_SEL = 14;
   // Configuration word 1 field positions
   localparam int C1_GAIN_LSB = 0;
   localparam int C1_GAIN_RANGE = 6;
   localparam int C1_LAT_LSB = 7;
   localparam int C1_FORMAT = 9;
   localparam int C1_RESOLUTION = 10;
   localparam int C1_PHASE = 11;
   localparam int C1_UPD_TIMING = 12;
   localparam int C1_SYNC_MODE = 13;
   localparam int C1_CONT_STAT = 14;
   // Writable masks (read-only status and destination bits cleared)
   localparam word_t C0_WR_MASK = 16'h6fb1;
   localparam word_t C1_WR_MASK = 16'h7fff;
   // Bits frozen while the device is enabled
   localparam word_t C0_LOCK_MASK = 16'h4800;
   localparam word_t C1_LOCK_MASK = 16'h2000;
   // Values after reset: host defaults, device enable held off
   localparam word_t C0_RESET = 16'h2530;
   localparam word_t C1_RESET = 16'h0040;
endpackage

// File: shift_link_if.sv
// Interface carrying the shift buffer between shifter and register bank.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface shift_link_if;
   import led_cfg_pkg::*;
   word_t word;          // Current shift buffer contents
   logic latch_fall;     // One-cycle pulse on latch enable falling edge
   logic reload;         // Request to overwrite the shift buffer
   word_t reload_word;   // Word loaded by a reload request
   modport shifter (output word, output latch_fall, input reload, input reload_word);
   modport bank (input word, input latch_fall, output reload, output reload_word);
endinterface

// File: serial_shifter.sv
// Serial shift buffer clocked by sampled shift-clock edges.
// Assumes shift clock, data and latch pins are synchronous to CLK.
`timescale 1ns/100ps
module serial_shifter (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic clr,
   input wire logic sck,
   input wire logic sdi,
   input wire logic latch,
   output logic sdo,
   shift_link_if.shifter lnk
);
   import led_cfg_pkg::*;
   word_t sr_r, sr_nxt;          // Shift buffer
   logic sck_r, sck_nxt;         // Previous shift clock level
   logic le_r, le_nxt;           // Previous latch level

   // Next state: reload has priority over a shift edge
   always_comb begin
      sr_nxt = sr_r;
      sck_nxt = sck;
      le_nxt = latch;
      if (clr) begin
         sr_nxt = '0;
      end else if (lnk.reload) begin
         sr_nxt = lnk.reload_word;
      end else if (sck && !sck_r) begin
         sr_nxt = {sr_r[WORD_W-2:0], sdi};
      end
   end

   // Registers, frozen while clock enable is low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sr_r <= '0;
         sck_r <= 1'b0;
         le_r <= 1'b0;
      end else if (ce) begin
         sr_r <= sr_nxt;
         sck_r <= sck_nxt;
         le_r <= le_nxt;
      end
   end

   assign lnk.word = sr_r;
   assign lnk.latch_fall = ce && le_r && !latch;
   assign sdo = sr_r[WORD_W-1];
endmodule

// File: fault_latch.sv
// Sticky per-channel open and short fault flags.
// Assumes fault inputs are synchronous levels from the channel detectors.
`timescale 1ns/100ps
module fault_latch #(
   parameter int CH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic clr,
   input wire logic dev_en,
   input wire logic [CH-1:0] open_in,
   input wire logic [CH-1:0] short_in,
   output logic [CH-1:0] open_q,
   output logic [CH-1:0] short_q
);
   logic [CH-1:0] open_r, open_nxt;     // Latched open faults
   logic [CH-1:0] short_r, short_nxt;   // Latched short faults
   logic en_r, en_nxt;                  // Previous device enable level
   logic toggle;                        // Device enable changed

   // At least one channel is needed
   if (CH < 1) begin : g_bad_ch
      $error("CH must be at least 1");
   end

   // Faults stay set; a new fault wins over the toggle clear
   always_comb begin
      toggle = dev_en ^ en_r;
      en_nxt = dev_en;
      open_nxt = (toggle ? '0 : open_r) | open_in;
      short_nxt = (toggle ? '0 : short_r) | short_in;
      if (clr) begin
         open_nxt = '0;
         short_nxt = '0;
         en_nxt = 1'b0;
      end
   end

   // Registers, frozen while clock enable is low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         open_r <= '0;
         short_r <= '0;
         en_r <= 1'b0;
      end else if (ce) begin
         open_r <= open_nxt;
         short_r <= short_nxt;
         en_r <= en_nxt;
      end
   end

   assign open_q = open_r;
   assign short_q = short_r;
endmodule

// File: led_cfg_regs.sv
// Configuration and status register bank of a sixteen-channel LED driver.
// Assumes the host shifts 16-bit words in MSB first and drops latch to act.
`timescale 1ns/100ps
module led_cfg_regs #(
   parameter int CH_COUNT = 16
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic REGULATOR_ENABLE_PIN,
   input wire logic SHIFT_CLK,
   input wire logic SHIFT_DATA_IN,
   input wire logic LATCH_ENABLE_SIGNAL,
   input wire logic READ_REQUEST,
   input wire logic DIM_CYCLE_START,
   input wire logic OVERTEMP_IN,
   input wire logic DAC_OVERFLOW_IN,
   input wire logic VOUT_OPTIMIZED_IN,
   input wire logic SCAN_VALID_IN,
   input wire logic PROTECTION_EVENT_IN,
   input wire logic [CH_COUNT-1:0] CH_OPEN_IN,
   input wire logic [CH_COUNT-1:0] CH_SHORT_IN,
   output logic SHIFT_DATA_OUT,
   output logic REGULATOR_ON,
   output led_cfg_pkg::word_t CONFIG_WORD_0,
   output led_cfg_pkg::word_t CONFIG_WORD_1,
   output logic [CH_COUNT-1:0] CHANNEL_FAULT,
   output logic [CH_COUNT-1:0] CHANNEL_DISCONNECT,
   output logic BRIGHTNESS_APPLY
);
   import led_cfg_pkg::*;

   // Channel count must fit the sixteen-channel layout
   if (CH_COUNT < 1 || CH_COUNT > 16) begin : g_bad_ch
      $error("CH_COUNT must lie between 1 and 16");
   end

   shift_link_if lnk ();                       // Shift buffer link
   word_t cfg0_r, cfg0_nxt;                    // Stored configuration word 0
   word_t cfg1_r, cfg1_nxt;                    // Stored configuration word 1
   logic reg_on_r, reg_on_nxt;                 // Regulator state
   logic pend_r, pend_nxt;                     // Brightness update waiting
   logic apply_r, apply_nxt;                   // Brightness apply pulse
   logic [CH_COUNT-1:0] disc_r, disc_nxt;      // Channel disconnect state
   logic [CH_COUNT-1:0] open_q;                // Sticky open faults
   logic [CH_COUNT-1:0] short_q;               // Sticky short faults
   logic powered_off;                          // Regulator pin low
   logic is_write;                             // Latch fall loads a word
   logic is_read;                              // Latch fall reads a word
   word_t rd0;                                 // Word 0 as read back
   word_t rd1;                                 // Word 1 as read back
   logic reload_c;                             // Shift buffer reload request
   word_t reload_word_c;                       // Word placed into shift buffer

   // Merge a write into a stored word, keeping masked and locked bits
   function automatic word_t merge(input word_t old_w, input word_t new_w,
                                   input word_t wr_mask, input word_t lock_mask,
                                   input logic locked);
      word_t m;
      m = locked ? (wr_mask & ~lock_mask) : wr_mask;
      merge = (old_w & ~m) | (new_w & m);
   endfunction

   // Sampled pin edges and the shift buffer
   serial_shifter u_shift (
      .clk(CLK),
      .resetn(RESETN),
      .ce(CE),
      .clr(powered_off),
      .sck(SHIFT_CLK),
      .sdi(SHIFT_DATA_IN),
      .latch(LATCH_ENABLE_SIGNAL),
      .sdo(SHIFT_DATA_OUT),
      .lnk(lnk.shifter)
   );

   // Sticky channel fault flags cleared by a device enable toggle
   fault_latch #(
      .CH(CH_COUNT)
   ) u_fault (
      .clk(CLK),
      .resetn(RESETN),
      .ce(CE),
      .clr(powered_off),
      .dev_en(cfg0_r[C0_DEV_EN]),
      .open_in(CH_OPEN_IN),
      .short_in(CH_SHORT_IN),
      .open_q(open_q),
      .short_q(short_q)
   );

   // Regulator follows its enable pin; logic held cleared while it is off
   assign powered_off = !REGULATOR_ENABLE_PIN;

   // Decode of the latched word and read-back values
   always_comb begin
      is_write = lnk.latch_fall && !READ_REQUEST && !powered_off;
      is_read = lnk.latch_fall && READ_REQUEST && !powered_off;
      // Read-only bits come from live status, never from storage
      rd0 = cfg0_r;
      rd0[C0_SCAN_VALID] = SCAN_VALID_IN;
      rd0[C0_DAC_OVF] = DAC_OVERFLOW_IN;
      rd0[C0_OVERTEMP] = OVERTEMP_IN;
      rd0[C0_PROT_EVT] = PROTECTION_EVENT_IN;
      rd0[C0_VOUT_OPT] = VOUT_OPTIMIZED_IN;
      rd0[DESTINATION_SELECT_BIT] = 1'b0;
      rd1 = cfg1_r;
      rd1[DESTINATION_SELECT_BIT] = 1'b1;
   end

   // Shift buffer reload: explicit read, or status after a write
   always_comb begin
      reload_c = 1'b0;
      reload_word_c = rd0;
      if (is_read) begin
         // Destination bit of the shifted word picks the word to return
         reload_c = 1'b1;
         reload_word_c = lnk.word[DESTINATION_SELECT_BIT] ? rd1 : rd0;
      end else if (is_write && cfg1_r[C1_CONT_STAT]) begin
         // Continuous status reading returns word 0 after each load
         reload_c = 1'b1;
         reload_word_c = rd0;
      end
   end

   assign lnk.reload = reload_c;
   assign lnk.reload_word = reload_word_c;

   // Next values of the configuration words
   always_comb begin
      cfg0_nxt = cfg0_r;
      cfg1_nxt = cfg1_r;
      reg_on_nxt = REGULATOR_ENABLE_PIN;
      if (powered_off) begin
         // Regulator off: the device returns to its reset configuration
         cfg0_nxt = C0_RESET;
         cfg1_nxt = C1_RESET;
      end else if (is_write) begin
         if (!lnk.word[DESTINATION_SELECT_BIT]) begin
            // Word 0: enable, auto-disconnect, threshold, mode, range, regulation
            // Range and slave bits hold while the device is enabled
            cfg0_nxt = merge(cfg0_r, lnk.word, C0_WR_MASK, C0_LOCK_MASK,
                             cfg0_r[C0_DEV_EN]);
         end else begin
            // Word 1: gain, format, resolution, phase, timing, sync, status
            // Sync pin mode holds while the device is enabled
            cfg1_nxt = merge(cfg1_r, lnk.word, C1_WR_MASK, C1_LOCK_MASK,
                             cfg0_r[C0_DEV_EN]);
         end
      end
   end

   // Configuration register flops
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         cfg0_r <= C0_RESET;
         cfg1_r <= C1_RESET;
         reg_on_r <= 1'b0;
      end else if (CE) begin
         cfg0_r <= cfg0_nxt;
         cfg1_r <= cfg1_nxt;
         reg_on_r <= reg_on_nxt;
      end
   end

   // Brightness update timing and channel disconnect control
   always_comb begin
      pend_nxt = pend_r;
      apply_nxt = 1'b0;
      if (powered_off) begin
         pend_nxt = 1'b0;
      end else if (lnk.latch_fall && !cfg1_r[C1_UPD_TIMING]) begin
         // Immediate mode: apply on the latch falling edge itself
         apply_nxt = 1'b1;
         pend_nxt = 1'b0;
      end else if (pend_r && DIM_CYCLE_START) begin
         // Deferred mode: apply at the next dimming cycle start
         apply_nxt = 1'b1;
         pend_nxt = 1'b0;
      end else if (lnk.latch_fall) begin
         // Deferred mode: remember the pending update
         pend_nxt = 1'b1;
      end
      // A latched fault cuts the channel only if its auto-disconnect is set
      disc_nxt = (open_q & {CH_COUNT{cfg0_r[C0_OPEN_AD]}})
               | (short_q & {CH_COUNT{cfg0_r[C0_SHORT_AD]}});
      if (powered_off) begin
         disc_nxt = '0;
      end
   end

   // Brightness and disconnect flops
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pend_r <= 1'b0;
         apply_r <= 1'b0;
         disc_r <= '0;
      end else if (CE) begin
         pend_r <= pend_nxt;
         apply_r <= apply_nxt;
         disc_r <= disc_nxt;
      end
   end

   // Outputs: stored words drive the analog and dimming sections
   assign REGULATOR_ON = reg_on_r;
   // Range, mode, phase, format and sync fields are decoded downstream
   assign CONFIG_WORD_0 = cfg0_r;
   assign CONFIG_WORD_1 = cfg1_r;
   assign CHANNEL_FAULT = open_q | short_q;
   assign CHANNEL_DISCONNECT = disc_r;
   assign BRIGHTNESS_APPLY = apply_r;
endmodule

// File: led_cfg_regs_chk.sv
// Checker of the LED driver configuration bank, watching its top ports.
// Assumes a single clock domain; bound onto every bank instance below.
`timescale 1ns/100ps
module led_cfg_regs_chk #(
   parameter int CH_COUNT = 16
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic REGULATOR_ENABLE_PIN,
   input wire logic LATCH_ENABLE_SIGNAL,
   input wire logic [CH_COUNT-1:0] CH_OPEN_IN,
   input wire logic REGULATOR_ON,
   input wire led_cfg_pkg::word_t CONFIG_WORD_0,
   input wire led_cfg_pkg::word_t CONFIG_WORD_1,
   input wire logic [CH_COUNT-1:0] CHANNEL_FAULT,
   input wire logic [CH_COUNT-1:0] CHANNEL_DISCONNECT,
   input wire logic BRIGHTNESS_APPLY
);
   import led_cfg_pkg::*;
   // All checks sample on the rising clock and rest during reset
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   // Regulator pin low returns the words to their reset values and drops the regulator output
   AST_REG_OFF: assert property (
      !REGULATOR_ENABLE_PIN |=> !REGULATOR_ON && CONFIG_WORD_0 == C0_RESET
         && CONFIG_WORD_1 == C1_RESET) else $error("regulator off did not clear state");
   // Status and destination bits are never stored
   AST_RO_BITS: assert property (
      (CONFIG_WORD_0 & ~C0_WR_MASK) == 16'h0 && !CONFIG_WORD_1[15])
      else $error("read-only bit stored");
   // Device enable freezes range and slave bits of word 0
   AST_LOCK0: assert property (
      CONFIG_WORD_0[0] && REGULATOR_ENABLE_PIN |=> $stable(CONFIG_WORD_0 & C0_LOCK_MASK))
      else $error("locked word 0 bit changed");
   // Device enable freezes the sync mode bit of word 1
   AST_LOCK1: assert property (
      CONFIG_WORD_0[0] && REGULATOR_ENABLE_PIN
         |=> CONFIG_WORD_1[13] == $past(CONFIG_WORD_1[13]))
      else $error("locked word 1 bit changed");
   // Disconnect only on a faulted channel with an auto-disconnect bit set
   AST_DISC: assert property (
      CHANNEL_DISCONNECT != '0 |-> (CHANNEL_DISCONNECT & ~$past(CHANNEL_FAULT)) == '0
         && $past(CONFIG_WORD_0[4] | CONFIG_WORD_0[5])) else $error("bad disconnect");
   // Faults hold while device enable stays put
   AST_STICKY: assert property (
      REGULATOR_ENABLE_PIN && $stable(CONFIG_WORD_0[0])
         |=> (CHANNEL_FAULT & $past(CHANNEL_FAULT)) == $past(CHANNEL_FAULT))
      else $error("fault flag dropped");
   // An open detect is captured on the next cycle
   AST_SET: assert property (
      REGULATOR_ENABLE_PIN && CE |=> (CHANNEL_FAULT & $past(CH_OPEN_IN)) == $past(CH_OPEN_IN))
      else $error("fault not captured");
   // Immediate update: latch fall gives an apply pulse shortly after
   AST_APPLY: assert property (
      $fell(LATCH_ENABLE_SIGNAL) && !CONFIG_WORD_1[12] && CE && REGULATOR_ENABLE_PIN
         |-> ##[1:2] BRIGHTNESS_APPLY) else $error("no apply pulse");
   // The apply pulse lasts one cycle
   AST_PULSE: assert property (
      BRIGHTNESS_APPLY |=> !BRIGHTNESS_APPLY) else $error("apply pulse too long");
endmodule
bind led_cfg_regs led_cfg_regs_chk #(.CH_COUNT(CH_COUNT)) i_led_cfg_regs_chk (
   .CLK(CLK), .RESETN(RESETN), .CE(CE), .REGULATOR_ENABLE_PIN(REGULATOR_ENABLE_PIN),
   .LATCH_ENABLE_SIGNAL(LATCH_ENABLE_SIGNAL), .CH_OPEN_IN(CH_OPEN_IN),
   .REGULATOR_ON(REGULATOR_ON), .CONFIG_WORD_0(CONFIG_WORD_0),
   .CONFIG_WORD_1(CONFIG_WORD_1), .CHANNEL_FAULT(CHANNEL_FAULT),
   .CHANNEL_DISCONNECT(CHANNEL_DISCONNECT), .BRIGHTNESS_APPLY(BRIGHTNESS_APPLY));

// File: led_host_model.sv
// Host model driving the serial shift pins and the regulator pin.
// Assumes pins change just after the rising edge of the shared clock.
`timescale 1ns/100ps
module led_host_model (
   input wire logic clk,
   output logic regulator_enable_pin,
   output logic shift_clk,
   output logic shift_data_in,
   output logic latch_enable_signal,
   output logic read_request,
   input wire logic shift_data_out
);
   import led_cfg_pkg::*;
   // Idle levels: device off, shift clock and latch low
   initial begin
      regulator_enable_pin = 1'b0;
      shift_clk = 1'b0;
      shift_data_in = 1'b0;
      latch_enable_signal = 1'b0;
      read_request = 1'b0;
   end
   // Switch the device on or off by the regulator pin
   task automatic power(input logic on);
      @(posedge clk);
      regulator_enable_pin <= on;
      @(posedge clk);
   endtask
   // Shift a word MSB first, then pulse latch; rd marks a read
   task automatic send_word(input word_t w, input logic rd);
      for (int i = WORD_W - 1; i >= 0; i--) begin
         @(posedge clk);
         shift_clk <= 1'b0;
         shift_data_in <= w[i];
         @(posedge clk);
         shift_clk <= 1'b1;
      end
      @(posedge clk);
      shift_clk <= 1'b0;
      latch_enable_signal <= 1'b1;
      read_request <= rd;
      @(posedge clk);
      latch_enable_signal <= 1'b0;
      repeat (2) @(posedge clk);
      // Data line released: show the inverse of the last bit
      shift_data_in <= ~w[0];
      read_request <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // Clock the buffer out, MSB first, sampling mid-cycle
   task automatic read_back(output word_t w);
      for (int i = WORD_W - 1; i >= 0; i--) begin
         @(negedge clk);
         w[i] = shift_data_out;
         @(posedge clk);
         shift_clk <= 1'b1;
         @(posedge clk);
         shift_clk <= 1'b0;
      end
   endtask
   // Default request: power up, then load both words with host defaults, device enable set in word 0
   task automatic default_load();
      power(1'b1);
      send_word(16'h2531, 1'b0);
      send_word(16'h8040, 1'b0);
   endtask
endmodule

// File: led_cfg_regs_bench.sv
// Self-checking bench of the LED driver configuration bank.
// Assumes the host model owns the serial and regulator pins.
`timescale 1ns/100ps
module led_cfg_regs_bench;
   import led_cfg_pkg::*;
   logic clk, resetn, ce, reg_pin, sck, sdi, le, rd, dim, ot, ovf, opt, scan, prot;
   logic sdo, reg_on, apply;
   logic [15:0] opn, sht, flt, disc;
   word_t w0, w1, got;
   int errors, cmp_count, apply_cnt, n;
   led_host_model i_led_host_model (.clk(clk), .regulator_enable_pin(reg_pin),
      .shift_clk(sck), .shift_data_in(sdi), .latch_enable_signal(le),
      .read_request(rd), .shift_data_out(sdo));
   led_cfg_regs #(.CH_COUNT(16)) i_led_cfg_regs (.CLK(clk), .RESETN(resetn), .CE(ce),
      .REGULATOR_ENABLE_PIN(reg_pin), .SHIFT_CLK(sck), .SHIFT_DATA_IN(sdi),
      .LATCH_ENABLE_SIGNAL(le), .READ_REQUEST(rd), .DIM_CYCLE_START(dim),
      .OVERTEMP_IN(ot), .DAC_OVERFLOW_IN(ovf), .VOUT_OPTIMIZED_IN(opt),
      .SCAN_VALID_IN(scan), .PROTECTION_EVENT_IN(prot), .CH_OPEN_IN(opn),
      .CH_SHORT_IN(sht), .SHIFT_DATA_OUT(sdo), .REGULATOR_ON(reg_on),
      .CONFIG_WORD_0(w0), .CONFIG_WORD_1(w1), .CHANNEL_FAULT(flt),
      .CHANNEL_DISCONNECT(disc), .BRIGHTNESS_APPLY(apply));
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Counts apply pulses seen
   always @(posedge clk) if (apply === 1'b1) apply_cnt <= apply_cnt + 1;
   // Compares one value and reports a mismatch
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask
   task automatic wr(input word_t w);
      i_led_host_model.send_word(w, 1'b0);
   endtask
   // Pulses channel fault detects for one cycle
   task automatic fault(input logic [15:0] o, input logic [15:0] s);
      @(posedge clk);
      opn <= o;
      sht <= s;
      @(posedge clk);
      opn <= 16'h0;
      sht <= 16'h0;
      tick(3);
   endtask
   // Reset values, then the host default load
   task automatic t_reset;
      cmp("word0", 16'h2530, w0);
      cmp("word1", 16'h0040, w1);
      i_led_host_model.default_load();
      tick(2);
      cmp("regulator", 16'h1, {15'h0, reg_on});
      cmp("word0", 16'h2531, w0);
      cmp("word1", 16'h0040, w1);
   endtask
   // Routing, read-only masking and locking under device enable
   task automatic t_mask;
      wr(16'h0000);
      wr(16'h7fff);
      cmp("word0", 16'h6fb1, w0);
      wr(16'h0001);
      cmp("word0", 16'h4801, w0);
      wr(16'hffff);
      cmp("word1", 16'h5fff, w1);
      wr(16'h0000);
      cmp("word0", 16'h4800, w0);
      wr(16'h0000);
      wr(16'h8000);
      cmp("word0", 16'h0000, w0);
      cmp("word1", 16'h0000, w1);
   endtask
   // Readback carries live status bits without storing them
   task automatic t_read;
      wr(16'h2030);
      @(posedge clk);
      {ot, ovf, opt, scan, prot} <= 5'h1f;
      i_led_host_model.send_word(16'h0000, 1'b1);
      i_led_host_model.read_back(got);
      cmp("read0", 16'h307e, got);
      cmp("word0", 16'h2030, w0);
      {ot, ovf, opt, scan, prot} <= 5'h00;
      i_led_host_model.send_word(16'h0000, 1'b1);
      i_led_host_model.read_back(got);
      cmp("read0", 16'h2030, got);
      i_led_host_model.send_word(16'h8000, 1'b1);
      i_led_host_model.read_back(got);
      cmp("read1", 16'h8000, got);
   endtask
   // Continuous status reloads the buffer after a write
   task automatic t_cont;
      wr(16'hc000);
      wr(16'h0030);
      i_led_host_model.read_back(got);
      // The reload captures word 0 as it stood at the latch fall
      cmp("status", 16'h2030, got);
      wr(16'h8000);
   endtask
   // Immediate versus deferred brightness update
   task automatic t_bright;
      n = apply_cnt;
      wr(16'h0030);
      tick(2);
      cmp("apply", 16'h1, 16'(apply_cnt - n));
      wr(16'h9000);
      n = apply_cnt;
      wr(16'h0030);
      cmp("apply", 16'h0, 16'(apply_cnt - n));
      dim <= 1'b1;
      @(posedge clk);
      dim <= 1'b0;
      tick(3);
      cmp("apply", 16'h1, 16'(apply_cnt - n));
      wr(16'h8000);
   endtask
   // Sticky faults, auto-disconnect, clear by enable toggle
   task automatic t_fault;
      fault(16'h0008, 16'h0100);
      cmp("fault", 16'h0108, flt);
      cmp("disconnect", 16'h0108, disc);
      wr(16'h0031);
      tick(2);
      cmp("fault", 16'h0000, flt);
      wr(16'h0000);
      fault(16'h0001, 16'h0000);
      cmp("fault", 16'h0001, flt);
      cmp("disconnect", 16'h0000, disc);
   endtask
   // Regulator off clears everything and ignores writes
   task automatic t_regoff;
      wr(16'h8005);
      i_led_host_model.power(1'b0);
      wr(16'h8007);
      cmp("regulator", 16'h0, {15'h0, reg_on});
      cmp("word1", 16'h0040, w1);
      cmp("fault", 16'h0000, flt);
      i_led_host_model.power(1'b1);
      tick(2);
      cmp("regulator", 16'h1, {15'h0, reg_on});
   endtask
   // Clock enable low freezes the bank; the same write then lands
   task automatic t_freeze;
      ce <= 1'b0;
      wr(16'h8005);
      ce <= 1'b1;
      tick(2);
      cmp("word1", 16'h0040, w1);
      wr(16'h8005);
      cmp("word1", 16'h0005, w1);
   endtask
   // Prints the verdict and ends the run
   task automatic print_verdict;
      if (errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end
   // Main sequence
   initial begin
      {resetn, dim, ot, ovf, opt, scan, prot} = 7'h00;
      ce = 1'b1;
      opn = 16'h0;
      sht = 16'h0;
      {errors, cmp_count, apply_cnt} = {32'd0, 32'd0, 32'd0};
      tick(5);
      resetn <= 1'b1;
      tick(2);
      t_reset();
      t_mask();
      t_read();
      t_cont();
      t_bright();
      t_fault();
      t_regoff();
      t_freeze();
      print_verdict();
   end
endmodule
